// *** cpps_pkg.sv ***
// package: constants and carriers for the charger power path supervisor
`default_nettype none
package cpps_pkg;
   // ==========================================================
   // register offsets and fields
   localparam logic [7:0] OPT_ADDR = 8'h12;
   localparam logic [7:0] STAT_ADDR = 8'h20;
   localparam logic [7:0] MASK_ADDR = 8'h21;
   localparam logic [7:0] CTRL_ADDR = 8'h22;
   localparam logic [7:0] LIVE_ADDR = 8'h23;
   localparam logic [15:0] OPT_RESET = 16'he000;
   localparam int OPT_LP_BIT = 15;
   localparam int OPT_WD_HI = 14;
   localparam int OPT_WD_LO = 13;
   localparam int CTRL_POWER_MONITOR_OUTPUT_BIT = 0;
   localparam int CTRL_THR_BIT = 1;
   localparam int CTRL_CMP_BIT = 2;
   localparam int CTRL_INH_BIT = 3;
   localparam int EV_OVP = 0;
   localparam int EV_BUS = 1;
   localparam int EV_WD = 2;
   localparam int EV_THR = 3;
   localparam int EV_AREM = 4;
   localparam int EV_W = 5;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int BUS_TIMEOUT_MS = 25;
   localparam int BUS_RESET_MAX_MS = 35;
   localparam int WD_DEGLITCH_MS = 10;
   localparam int THROTTLE_MS = 10;
   localparam logic [17:0] WD_44_MS = 18'd44000;
   localparam logic [17:0] WD_88_MS = 18'd88000;
   localparam logic [17:0] WD_175_MS = 18'd175000;
   // ==========================================================
   // comparator results from the analog front end
   typedef struct packed {
      logic undervoltage_lockout_ok;
      logic ovp_enter;
      logic above_recover;
      logic det_bias;
      logic det_good;
      logic vcc_srn_rise;
      logic srn_over_srp;
      logic gate_sag;
      logic input_limit;
      logic charge_at_zero;
      logic over_current;
      logic cmp_trip;
      logic bat_present;
   } cpps_cmp_t;
endpackage : cpps_pkg
`default_nettype wire

// *** cpps_top.sv ***
// module: power path supervisor, watchdog, bus timeout and throttle
`timescale 1ns/10ps
`default_nettype none
module cpps_top
   import cpps_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire cpps_cmp_t cmp_i,
   input wire logic scl_i,
   input wire logic wd_kick_i,
   output logic adapter_good_flag_o,
   output logic adapter_good_flag_oe_o,
   output logic adapter_gate_drive_o,
   output logic battery_gate_drive_o,
   output logic converter_en_o,
   output logic charge_en_o,
   output logic charge_reduce_o,
   output logic supplement_o,
   output logic internal_regulator_o,
   output logic processor_throttle_flag_o,
   output logic processor_throttle_flag_oe_o,
   output logic low_power_o,
   output logic bus_accept_o,
   output logic comm_reset_o,
   output logic irq_o
);
   // ==========================================================
   // synchronisers
   cpps_cmp_t cmp_meta;
   cpps_cmp_t s;
   logic [1:0] scl_meta;
   logic [1:0] kick_meta;
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         cmp_meta <= cmp_i;
         s <= cmp_meta;
         scl_meta <= {scl_meta[0], scl_i};
         kick_meta <= {kick_meta[0], wd_kick_i};
      end
   end
   wire scl_s = scl_meta[1];
   wire kick_s = kick_meta[1];

   // ==========================================================
   // millisecond tick
   logic [31:0] ms_cnt;
   wire tick = (ms_cnt == 32'(MS_CYC - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i) ms_cnt <= 32'h0;
      else if (ce_i) ms_cnt <= tick ? 32'h0 : ms_cnt + 32'h1;
   end

   // ==========================================================
   // registers
   logic [15:0] opt;
   logic [3:0] ctrl;
   logic [EV_W-1:0] stat;
   logic [EV_W-1:0] mask;
   logic [EV_W-1:0] ev;
   wire wr_opt = wr_i && (addr_i == OPT_ADDR);
   wire wr_stat = wr_i && (addr_i == STAT_ADDR);
   wire wr_mask = wr_i && (addr_i == MASK_ADDR);
   wire wr_ctrl = wr_i && (addr_i == CTRL_ADDR);
   wire power_monitor_output_en = ctrl[CTRL_POWER_MONITOR_OUTPUT_BIT];
   wire thr_en = ctrl[CTRL_THR_BIT];
   wire cmp_en = ctrl[CTRL_CMP_BIT];
   wire chg_inh = ctrl[CTRL_INH_BIT];
   wire [EV_W-1:0] w1c = wr_stat ? wdata_i[EV_W-1:0] : '0;
   wire [EV_W-1:0] next_stat = (stat & ~w1c) | ev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opt <= OPT_RESET;
         ctrl <= 4'h0;
         stat <= '0;
         mask <= '0;
      end else if (ce_i) begin
         if (wr_opt) opt <= wdata_i;
         if (wr_ctrl) ctrl <= wdata_i[3:0];
         if (wr_mask) mask <= wdata_i[EV_W-1:0];
         stat <= next_stat; // set wins over clear
      end
   end

   // ==========================================================
   // overvoltage latch and power path
   logic ovp;
   always_ff @(posedge clk_i) begin
      if (rst_i) ovp <= 1'b0;
      else if (ce_i) begin
         if (s.ovp_enter) ovp <= 1'b1;
         else if (!s.above_recover) ovp <= 1'b0;
      end
   end
   wire good = s.undervoltage_lockout_ok && !ovp && s.det_good && s.vcc_srn_rise;
   wire bat_ok = s.undervoltage_lockout_ok && s.srn_over_srp;
   // adapter switches only follow adapter good, so no adapter keeps them off
   wire next_ac_sw = good;
   wire next_supp = good && s.input_limit && s.charge_at_zero;
   wire next_bat_sw = (!good && bat_ok) || next_supp;
   wire next_reduce = good && s.input_limit;
   wire next_conv = next_ac_sw && !s.gate_sag;
   wire next_internal_regulator = s.det_bias || power_monitor_output_en || thr_en || cmp_en;

   // ==========================================================
   // bus clock low timeout
   logic [5:0] scl_ms;
   logic scl_done;
   wire scl_hit = tick && !scl_s && !scl_done
      && (scl_ms == 6'(BUS_TIMEOUT_MS));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_ms <= 6'h0;
         scl_done <= 1'b0;
      end else if (ce_i) begin
         if (scl_s) begin
            scl_ms <= 6'h0;
            scl_done <= 1'b0;
         end else if (tick && !scl_done) begin
            scl_ms <= scl_ms + 6'h1;
            if (scl_hit) scl_done <= 1'b1;
         end
      end
   end

   // ==========================================================
   // watchdog reset deglitch and watchdog timer
   function automatic logic [17:0] wd_limit(input logic [1:0] code);
      case (code)
         2'b01: wd_limit = WD_44_MS;
         2'b10: wd_limit = WD_88_MS;
         default: wd_limit = WD_175_MS;
      endcase
   endfunction : wd_limit
   wire [1:0] wd_code = opt[OPT_WD_HI:OPT_WD_LO];
   logic [3:0] deg_ms;
   logic deg_done;
   wire kick_ok = tick && kick_s && !deg_done
      && (deg_ms == 4'(WD_DEGLITCH_MS));
   logic [17:0] wd_ms;
   logic wd_exp;
   // code 00 keeps the watchdog from expiring; wd_ms still counts
   wire wd_hit = tick && (wd_code != 2'b00) && !wd_exp
      && (wd_ms >= wd_limit(wd_code) - 18'h1);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         deg_ms <= 4'h0;
         deg_done <= 1'b0;
      end else if (ce_i) begin
         if (!kick_s) begin
            deg_ms <= 4'h0;
            deg_done <= 1'b0;
         end else if (tick && !deg_done) begin
            deg_ms <= deg_ms + 4'h1;
            if (kick_ok) deg_done <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_ms <= 18'h0;
         wd_exp <= 1'b0;
      end else if (ce_i) begin
         if (kick_ok) begin
            wd_ms <= 18'h0;
            wd_exp <= 1'b0;
         end else if (wd_hit) wd_exp <= 1'b1;
         else if (tick && !wd_exp) wd_ms <= wd_ms + 18'h1;
      end
   end
   wire next_chg = good && !chg_inh && !wd_exp;

   // ==========================================================
   // throttle pulse
   logic good_d;
   logic bat_d;
   logic thr_act;
   logic [3:0] thr_ms;
   wire ac_gone = good_d && !good;
   wire bat_gone = bat_d && !s.bat_present;
   wire thr_hold = s.over_current || s.cmp_trip;
   wire thr_trig = thr_en && (thr_hold || ac_gone || bat_gone);
   wire thr_end = tick && (thr_ms == 4'(THROTTLE_MS));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         good_d <= 1'b0;
         bat_d <= 1'b0;
         thr_act <= 1'b0;
         thr_ms <= 4'h0;
      end else if (ce_i) begin
         good_d <= good;
         bat_d <= s.bat_present;
         if (thr_trig && !thr_act) begin
            thr_act <= 1'b1;
            thr_ms <= 4'h0;
         end else if (thr_act && thr_end) begin
            thr_ms <= 4'h0;
            // still active at the end: extend
            if (!(thr_en && thr_hold)) thr_act <= 1'b0;
         end else if (thr_act && tick) thr_ms <= thr_ms + 4'h1;
      end
   end

   // ==========================================================
   // events and outputs
   logic ovp_d;
   always_ff @(posedge clk_i) begin
      if (rst_i) ovp_d <= 1'b0;
      else if (ce_i) ovp_d <= ovp;
   end
   always_comb begin
      ev = '0;
      ev[EV_OVP] = ovp && !ovp_d;
      ev[EV_BUS] = scl_hit;
      ev[EV_WD] = wd_hit;
      ev[EV_THR] = thr_trig && !thr_act;
      ev[EV_AREM] = ac_gone;
   end
   wire [15:0] live = {8'h0, thr_act, wd_exp, scl_done, ovp,
      good, bat_ok, s.det_bias, s.undervoltage_lockout_ok};
   wire [15:0] next_rdata =
      (addr_i == OPT_ADDR) ? opt :
      (addr_i == STAT_ADDR) ? 16'(stat) :
      (addr_i == MASK_ADDR) ? 16'(mask) :
      (addr_i == CTRL_ADDR) ? 16'(ctrl) :
      (addr_i == LIVE_ADDR) ? live : 16'h0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0;
         adapter_good_flag_oe_o <= 1'b1;
         adapter_gate_drive_o <= 1'b0;
         battery_gate_drive_o <= 1'b0;
         converter_en_o <= 1'b0;
         charge_en_o <= 1'b0;
         charge_reduce_o <= 1'b0;
         supplement_o <= 1'b0;
         internal_regulator_o <= 1'b0;
         processor_throttle_flag_oe_o <= 1'b0;
         low_power_o <= 1'b1;
         bus_accept_o <= 1'b0;
         comm_reset_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         rdata_o <= rd_i ? next_rdata : 16'h0;
         adapter_good_flag_oe_o <= !good;
         adapter_gate_drive_o <= next_ac_sw;
         battery_gate_drive_o <= next_bat_sw;
         converter_en_o <= next_conv;
         charge_en_o <= next_chg;
         charge_reduce_o <= next_reduce;
         supplement_o <= next_supp;
         internal_regulator_o <= next_internal_regulator;
         processor_throttle_flag_oe_o <= thr_act;
         low_power_o <= opt[OPT_LP_BIT];
         bus_accept_o <= s.undervoltage_lockout_ok;
         comm_reset_o <= scl_hit;
         irq_o <= |(next_stat & mask);
      end
   end
   // open-drain pins only ever pull low
   always_ff @(posedge clk_i) begin
      adapter_good_flag_o <= 1'b0;
      processor_throttle_flag_o <= 1'b0;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);
   logic [31:0] thr_len;
   always_ff @(posedge clk_i) begin
      if (rst_i || !thr_act) thr_len <= 32'h0;
      else if (ce_i) thr_len <= thr_len + 32'h1;
   end
   // cycles the synced kick has stood high, independent of the ms tick
   logic [31:0] kick_len;
   always_ff @(posedge clk_i) begin
      if (rst_i || !kick_s) kick_len <= 32'h0;
      else if (ce_i) kick_len <= kick_len + 32'h1;
   end
   sequence ovp_rise;
      $rose(ovp);
   endsequence
   sequence sw_off;
      !adapter_gate_drive_o && adapter_good_flag_oe_o;
   endsequence
   ovp_cut_a: assert property (ovp_rise |=> sw_off)
      else $error("adapter path not cut on overvoltage");
   ovp_hold_a: assert property (ovp && s.above_recover |=> ovp)
      else $error("overvoltage latch dropped early");
   good_cond_a: assert property (!adapter_good_flag_oe_o
      |-> $past(s.undervoltage_lockout_ok && !ovp && s.det_good && s.vcc_srn_rise))
      else $error("adapter good released without its conditions");
   bat_cond_a: assert property (battery_gate_drive_o && !supplement_o
      |-> $past(bat_ok))
      else $error("battery switch on without conditions");
   excl_a: assert property (adapter_gate_drive_o && !supplement_o
      |-> !battery_gate_drive_o)
      else $error("both sources connected");
   conv_stop_a: assert property (s.gate_sag |=> !converter_en_o)
      else $error("converter ran with sagging gate");
   internal_regulator_on_a: assert property (s.det_bias || thr_en |=> internal_regulator_o)
      else $error("regulator off while needed");
   lp_reset_a: assert property ($past(rst_i) |-> low_power_o)
      else $error("not in low power after reset");
   bus_to_a: assert property (comm_reset_o
      |-> $past(scl_ms == 6'(BUS_TIMEOUT_MS) && !scl_s))
      else $error("bus timeout at wrong count");
   thr_min_a: assert property ($fell(thr_act)
      |-> $past(thr_len) >= 32'(THROTTLE_MS * MS_CYC))
      else $error("throttle pulse too short");
   kick_a: assert property (kick_ok |-> kick_len >= 32'(WD_DEGLITCH_MS * MS_CYC))
      else $error("watchdog reset taken too early");
endmodule : cpps_top
`default_nettype wire

// *** cpps_host_model.sv ***
// host side of the bus link: clock frames and a stuck-low clock on demand
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host clock model
module cpps_host_model (
   input wire logic frame_i,
   input wire logic stall_i,
   output logic scl_o
);
   // pulled-up line: high between frames, no free-running clock
   initial begin
      scl_o = 1'b1;
      forever begin
         @(posedge frame_i or posedge stall_i);
         if (stall_i) begin
            scl_o = 1'b0;
            wait (!stall_i);
            scl_o = 1'b1;
         end else begin
            #7;
            repeat (9) begin
               #80 scl_o = 1'b0;
               #80 scl_o = 1'b1;
            end
         end
      end
   end
endmodule : cpps_host_model
`default_nettype wire

// *** tb_top.sv ***
// testbench: supervisor driven through registers, comparators and bus clock
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench
module tb_top;
   import cpps_pkg::*;
   localparam int MSC = 50;
   logic clk_i, rst_i, wr_i, rd_i, wd_kick_i, frame, stall, ce, agf, ptf;
   logic [7:0] addr_i;
   logic [15:0] wdata_i, rdata_o, d, v;
   cpps_cmp_t cmp;
   wire scl;
   logic ag_oe, agd, bgd, cen, chg, red, sup, reg_on, thr_oe, lp, bacc, crst, irq;
   int n_errors = 0;
   int n_compared = 0;
   int n_creset = 0;

   cpps_top #(.MS_CYC(MSC)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .cmp_i(cmp), .scl_i(scl), .wd_kick_i(wd_kick_i), .adapter_good_flag_o(agf),
      .adapter_good_flag_oe_o(ag_oe), .adapter_gate_drive_o(agd),
      .battery_gate_drive_o(bgd), .converter_en_o(cen), .charge_en_o(chg),
      .charge_reduce_o(red), .supplement_o(sup), .internal_regulator_o(reg_on),
      .processor_throttle_flag_o(ptf), .processor_throttle_flag_oe_o(thr_oe),
      .low_power_o(lp), .bus_accept_o(bacc), .comm_reset_o(crst), .irq_o(irq));
   cpps_host_model host (.frame_i(frame), .stall_i(stall), .scl_o(scl));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (crst === 1'b1) n_creset++;
   end

   // option word is plain storage: every bit reads back
   function automatic logic [15:0] opt_exp(input logic [15:0] w);
      return w;
   endfunction : opt_exp
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [15:0] w);
      addr_i <= a;
      wdata_i <= w;
      wr_i <= 1'b1;
      step(1);
      wr_i <= 1'b0;
      step(1);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      addr_i <= a;
      rd_i <= 1'b1;
      step(1);
      rd_i <= 1'b0;
      d = rdata_o;
      step(1);
   endtask : rd
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // hang guard, well above the ~4200 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      wrap_up();
   end

   initial begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      wd_kick_i = 1'b0;
      frame = 1'b0;
      stall = 1'b0;
      ce = 1'b1;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      cmp = '0;
      void'($urandom(88));
      step(6);
      rst_i <= 1'b0;
      step(3);
      rd(OPT_ADDR);
      chk("option reset", OPT_RESET, d);
      chk("low power", 16'h0001, 16'(lp));
      chk("drain data", 16'h0000, 16'({agf, ptf}));
      rd(8'h7f);
      chk("unmapped", 16'h0000, d);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
         wr(OPT_ADDR, v);
         rd(OPT_ADDR);
         chk("option", opt_exp(v), d);
         chk("low power", 16'(v[15]), 16'(lp));
      end
      wr(OPT_ADDR, OPT_RESET);
      // battery only
      cmp.undervoltage_lockout_ok <= 1'b1;
      cmp.bat_present <= 1'b1;
      step(8);
      chk("battery sw", 16'h0000, 16'(bgd));
      cmp.srn_over_srp <= 1'b1;
      step(8);
      chk("battery sw", 16'h0001, 16'(bgd));
      chk("adapter sw", 16'h0000, 16'(agd));
      chk("bus accept", 16'h0001, 16'(bacc));
      chk("regulator", 16'h0000, 16'(reg_on));
      wr(CTRL_ADDR, 16'h0004);
      step(2);
      chk("regulator", 16'h0001, 16'(reg_on));
      wr(CTRL_ADDR, 16'h0000);
      // adapter attach, sense condition still missing
      cmp.det_bias <= 1'b1;
      cmp.det_good <= 1'b1;
      step(8);
      chk("regulator", 16'h0001, 16'(reg_on));
      chk("good pull", 16'h0001, 16'(ag_oe));
      chk("adapter sw", 16'h0000, 16'(agd));
      cmp.vcc_srn_rise <= 1'b1;
      step(8);
      chk("good pull", 16'h0000, 16'(ag_oe));
      chk("adapter sw", 16'h0001, 16'(agd));
      chk("battery sw", 16'h0000, 16'(bgd));
      // overvoltage entry, latch, recovery
      wr(MASK_ADDR, 16'h0001);
      cmp.above_recover <= 1'b1;
      cmp.ovp_enter <= 1'b1;
      step(8);
      chk("good pull", 16'h0001, 16'(ag_oe));
      chk("adapter sw", 16'h0000, 16'(agd));
      chk("charge", 16'h0000, 16'(chg));
      chk("battery sw", 16'h0001, 16'(bgd));
      chk("irq", 16'h0001, 16'(irq));
      cmp.ovp_enter <= 1'b0;
      step(8);
      chk("adapter sw", 16'h0000, 16'(agd));
      chk("good pull", 16'h0001, 16'(ag_oe));
      cmp.above_recover <= 1'b0;
      step(8);
      chk("good pull", 16'h0000, 16'(ag_oe));
      chk("adapter sw", 16'h0001, 16'(agd));
      chk("battery sw", 16'h0000, 16'(bgd));
      rd(STAT_ADDR);
      chk("ovp status", 16'h0001, 16'(d[EV_OVP]));
      wr(STAT_ADDR, 16'h001f);
      step(2);
      chk("irq", 16'h0000, 16'(irq));
      // gate sag, input limit, supplement
      // clock enable low: the sag must not reach the outputs yet
      ce <= 1'b0;
      cmp.gate_sag <= 1'b1;
      step(8);
      chk("converter frozen", 16'h0001, 16'(cen));
      ce <= 1'b1;
      step(8);
      chk("converter", 16'h0000, 16'(cen));
      cmp.gate_sag <= 1'b0;
      cmp.input_limit <= 1'b1;
      step(8);
      chk("reduce", 16'h0001, 16'(red));
      chk("supplement", 16'h0000, 16'(sup));
      cmp.charge_at_zero <= 1'b1;
      step(8);
      chk("supplement", 16'h0001, 16'(sup));
      chk("battery sw", 16'h0001, 16'(bgd));
      cmp.input_limit <= 1'b0;
      cmp.charge_at_zero <= 1'b0;
      // throttle pulse, extension, battery removal
      wr(CTRL_ADDR, 16'h0002);
      step(2);
      cmp.over_current <= 1'b1;
      step(5);
      cmp.over_current <= 1'b0;
      step(9 * MSC);
      chk("throttle", 16'h0001, 16'(thr_oe));
      step(3 * MSC);
      chk("throttle", 16'h0000, 16'(thr_oe));
      cmp.over_current <= 1'b1;
      step(15 * MSC);
      chk("throttle", 16'h0001, 16'(thr_oe));
      cmp.over_current <= 1'b0;
      step(13 * MSC);
      chk("throttle", 16'h0000, 16'(thr_oe));
      cmp.bat_present <= 1'b0;
      step(8);
      chk("throttle", 16'h0001, 16'(thr_oe));
      wr(CTRL_ADDR, 16'h0000);
      // watchdog kick held past the deglitch time
      wd_kick_i <= 1'b1;
      step(12 * MSC);
      wd_kick_i <= 1'b0;
      rd(LIVE_ADDR);
      chk("wd expired", 16'h0000, 16'(d[6]));
      // normal frame, then clock stuck low
      frame <= 1'b1;
      step(2);
      frame <= 1'b0;
      step(100);
      stall <= 1'b1;
      step(24 * MSC);
      chk("bus reset count", 16'h0000, 16'(n_creset));
      step(3 * MSC);
      chk("bus reset count", 16'h0001, 16'(n_creset));
      stall <= 1'b0;
      step(8);
      rd(STAT_ADDR);
      chk("bus status", 16'h0001, 16'(d[EV_BUS]));
      // mid-run reset must bring back low power mode
      wr(OPT_ADDR, 16'h0000);
      step(1);
      chk("low power", 16'h0000, 16'(lp));
      rst_i <= 1'b1;
      step(6);
      rst_i <= 1'b0;
      step(1);
      chk("low power", 16'h0001, 16'(lp));
      rd(OPT_ADDR);
      chk("option reset", OPT_RESET, d);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
